/* File: design/bcq_lane_map.sv */
`timescale 1ns/1ps
`default_nettype none
module bcq_lane_map (
	input  wire logic [1:0]  size,
	input  wire logic [1:0]  addr_lo,
	output logic             lword_n,
	output logic             ds0_n,
	output logic             ds1_n,
	output logic [1:0]       shift,
	output logic             legal
);
	always_comb begin
		lword_n = 1'b1;
		ds0_n   = 1'b1;
		ds1_n   = 1'b1;
		shift   = 2'h0;
		legal   = 1'b1;
		unique case (size) // RL13
			2'h0: begin // RL15
				ds0_n = ~addr_lo[0];
				ds1_n = addr_lo[0];
				shift = addr_lo[0] ? 2'h0 : 2'h1; // RL12
			end
			2'h1: begin
				ds0_n = 1'b0;
				ds1_n = 1'b0;
				legal = ~addr_lo[0];
				shift = 2'h0;
			end
			2'h2: begin
				ds0_n   = 1'b0;
				ds1_n   = 1'b0;
				lword_n = 1'b0;
				legal   = (addr_lo == 2'h0);
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: design/bcq_master.sv */
`timescale 1ns/1ps
`default_nettype none
module bcq_master (
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire logic                     req_valid,
	output logic                          req_ready,
	input  wire bcq_pkg::bcq_req_t        req,
	output logic                          rsp_valid,
	output bcq_pkg::bcq_rsp_t             rsp,
	output bcq_pkg::bcq_bus_t             bus,
	output logic [bcq_pkg::DATA_W-1:0]    data_o,
	output logic [bcq_pkg::DATA_W-1:0]    data_oe_n,
	input  wire logic [bcq_pkg::DATA_W-1:0] data_i,
	input  wire logic                     dtack_n,
	input  wire logic                     berr_n
);
	typedef enum logic [2:0] {IDLE, ADDR, STROBE, RELEASE, DONE} bcq_state_t;

	function automatic logic [bcq_pkg::AM_W-1:0] mode_am(input bcq_pkg::bcq_mode_t m); // RL14
		unique case (m)
			bcq_pkg::short_address_class:    mode_am = bcq_pkg::AM_SHORT;
			bcq_pkg::standard_address_class: mode_am = bcq_pkg::AM_STANDARD;
			bcq_pkg::extended_address_class: mode_am = bcq_pkg::AM_EXTENDED;
			bcq_pkg::iack_mode:              mode_am = bcq_pkg::AM_SHORT;
		endcase
	endfunction

	function automatic logic [bcq_pkg::ADDR_W-1:0] mode_mask(input bcq_pkg::bcq_mode_t m);
		unique case (m)
			bcq_pkg::short_address_class:    mode_mask = bcq_pkg::MASK_SHORT;
			bcq_pkg::standard_address_class: mode_mask = bcq_pkg::MASK_STANDARD;
			bcq_pkg::extended_address_class: mode_mask = bcq_pkg::MASK_EXTENDED;
			bcq_pkg::iack_mode:              mode_mask = bcq_pkg::MASK_SHORT;
		endcase
	endfunction

	bcq_state_t        state_r, state_nxt;
	bcq_pkg::bcq_req_t req_r, req_nxt;
	bcq_pkg::bcq_bus_t bus_r, bus_nxt;
	bcq_pkg::bcq_rsp_t rsp_r, rsp_nxt;
	logic [7:0]        cnt_r, cnt_nxt;
	logic [bcq_pkg::DATA_W-1:0] dout_r, dout_nxt;
	logic              drive_r, drive_nxt;
	logic              lword_n, ds0_n, ds1_n, legal;
	logic [1:0]        shift;
	logic [bcq_pkg::DATA_W-1:0] rd_shifted;

	bcq_lane_map u_lane (
		.size    (req_r.size),
		.addr_lo (req_r.addr[1:0]),
		.lword_n (lword_n),
		.ds0_n   (ds0_n),
		.ds1_n   (ds1_n),
		.shift   (shift),
		.legal   (legal)
	);

	// Single bytes and halfwords ride the low lanes; odd bytes always on D00-D07.
	assign rd_shifted = (shift == 2'h1) ? (data_i >> 8) : data_i; // RL12

	always_comb begin
		state_nxt = state_r;
		req_nxt   = req_r;
		bus_nxt   = bus_r;
		rsp_nxt   = rsp_r;
		cnt_nxt   = cnt_r;
		dout_nxt  = dout_r;
		drive_nxt = drive_r;
		unique case (state_r)
			IDLE: begin
				if (req_valid) begin
					// Interrupt acknowledge mode is never issued by this master.
					if (req.mode == bcq_pkg::iack_mode) begin // RL8 RL11
						rsp_nxt   = '{status: bcq_pkg::ST_REFUSED, rdata: '0};
						state_nxt = DONE;
					end else begin
						req_nxt   = req;
						state_nxt = ADDR;
					end
				end
			end
			ADDR: begin
				if (!legal) begin
					rsp_nxt   = '{status: bcq_pkg::ST_REFUSED, rdata: '0};
					state_nxt = DONE;
				end else begin
					bus_nxt.addr    = req_r.addr & mode_mask(req_r.mode); // RL3 RL4
					bus_nxt.address_modifier_code = mode_am(req_r.mode); // RL5
					bus_nxt.iack_n  = 1'b1; // RL8 RL9
					bus_nxt.write_n = ~req_r.write;
					bus_nxt.lword_n = lword_n;
					bus_nxt.as_n    = 1'b0;
					dout_nxt  = (shift == 2'h1) ? (req_r.wdata << 8) : req_r.wdata;
					drive_nxt = req_r.write;
					cnt_nxt   = 8'h00;
					state_nxt = STROBE;
				end
			end
			STROBE: begin
				bus_nxt.ds0_n = ds0_n;
				bus_nxt.ds1_n = ds1_n;
				cnt_nxt = cnt_r + 8'h01;
				if (!bus_r.ds0_n || !bus_r.ds1_n) begin
					if (!dtack_n || !berr_n || cnt_r == 8'(bcq_pkg::ACK_TIMEOUT)) begin
						rsp_nxt.status = !dtack_n ? bcq_pkg::ST_OK :
							(!berr_n ? bcq_pkg::ST_BUSERR : bcq_pkg::ST_TIMEOUT);
						rsp_nxt.rdata = rd_shifted;
						bus_nxt.ds0_n = 1'b1;
						bus_nxt.ds1_n = 1'b1;
						state_nxt = RELEASE;
					end
				end
			end
			RELEASE: begin
				bus_nxt.as_n    = 1'b1;
				bus_nxt.lword_n = 1'b1;
				drive_nxt = 1'b0;
				if (dtack_n && berr_n) begin
					state_nxt = DONE;
				end
			end
			DONE: begin
				state_nxt = IDLE;
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= IDLE;
			req_r   <= '0;
			bus_r   <= '{addr: '0, address_modifier_code: '0, lword_n: 1'b1, ds0_n: 1'b1,
				ds1_n: 1'b1, write_n: 1'b1, as_n: 1'b1, iack_n: 1'b1};
			rsp_r   <= '0;
			cnt_r   <= 8'h00;
			dout_r  <= '0;
			drive_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_r   <= req_nxt;
			bus_r   <= bus_nxt;
			rsp_r   <= rsp_nxt;
			cnt_r   <= cnt_nxt;
			dout_r  <= dout_nxt;
			drive_r <= drive_nxt;
		end
	end

	assign req_ready = (state_r == IDLE);
	assign rsp_valid = (state_r == DONE);
	assign rsp       = rsp_r;
	assign bus       = bus_r;
	assign data_o    = dout_r;
	assign data_oe_n = {bcq_pkg::DATA_W{~drive_r}};

	sequence addr_phase_s;
		state_r == ADDR && legal;
	endsequence

	sequence strobes_low_s;
		!bus.ds0_n || !bus.ds1_n;
	endsequence

	sequence byte_strobe_s;
		state_r == STROBE && req_r.size == 2'h0;
	endsequence

	iack_high_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL8
		!bus.as_n
		|-> bus.iack_n)
		else $error("Interrupt acknowledge low during address phase.");

	am_code_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL5
		addr_phase_s
		|=> bus.address_modifier_code == mode_am(req_r.mode))
		else $error("Modifier code mismatch.");

	addr_width_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL3
		addr_phase_s
		|=> (bus.addr & ~mode_mask(req_r.mode)) == '0)
		else $error("Address wider than mode.");

	strobe_after_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL4
		addr_phase_s
		|=> !bus.as_n ##1 strobes_low_s)
		else $error("Strobe not after address.");

	no_iack_req_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL11
		(state_r == IDLE && req_valid && req.mode == bcq_pkg::iack_mode)
		|=> rsp_valid)
		else $error("Interrupt mode request not refused.");

	refused_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL13
		(state_r == ADDR && !legal)
		|=> bus.as_n && rsp_valid)
		else $error("Refused request reached the bus.");

	odd_lane_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL12
		(state_r == STROBE && req_r.size == 2'h0 && req_r.addr[0])
		|=> bus.ds1_n && bus.lword_n && (!req_r.write || data_o[7:0] == req_r.wdata[7:0]))
		else $error("Odd byte not on the low lane.");

	byte_single_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL15
		byte_strobe_s
		|=> bus.ds0_n || bus.ds1_n)
		else $error("Both strobes low on a byte cycle.");

	word_lword_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL13
		(state_r == STROBE && req_r.size == 2'h2)
		|-> !bus.lword_n)
		else $error("Word cycle without long word select.");

	oe_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL13
		(data_oe_n != '1)
		|-> !bus.write_n)
		else $error("Data lines driven on a read cycle.");

	addr_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL3
		(state_r == STROBE)
		|=> $stable(bus.addr) && $stable(bus.address_modifier_code))
		else $error("Address changed during the strobe phase.");
endmodule
`default_nettype wire

/* File: design/bcq_pkg.sv */
// Functional notes
// RL1: Monitor watches address lines per mode width.
// RL2: Address strobe observation is optional.
// RL3: Master drives address every cycle.
// RL4: Address classes are 16, 24, 32 bits.
// RL5: Master drives modifier code with address.
// RL6: Responder accepts only its address classes.
// RL7: Responder decodes all modifier lines.
// RL8: Master keeps interrupt acknowledge high.
// RL9: Acknowledge high by drive or release.
// RL10: No response while interrupt acknowledge low.
// RL11: Acknowledge low marks interrupt acknowledge cycle.
// RL12: Odd-byte-only responder uses bytes 1, 3.
// RL13: Four data width classes exist.
// RL14: Wide masters should also offer narrow addressing.
// RL15: Halfword master should offer byte cycles.
// RL16: Wide responders should accept narrow transfers.
// RL17: Byte responder never acknowledges double-byte cycles.
// RL18: Responder compares mode lines, needs acknowledge high.
package bcq_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int AM_W   = 6;
	localparam logic [AM_W-1:0] AM_SHORT    = 6'h29;
	localparam logic [AM_W-1:0] AM_STANDARD = 6'h39;
	localparam logic [AM_W-1:0] AM_EXTENDED = 6'h09;
	localparam logic [ADDR_W-1:0] MASK_SHORT    = 32'h0000fffe;
	localparam logic [ADDR_W-1:0] MASK_STANDARD = 32'h00fffffe;
	localparam logic [ADDR_W-1:0] MASK_EXTENDED = 32'hfffffffe;
	localparam logic [3:0] LANES_QUAD = 4'hf;
	localparam int STROBE_SETUP = 1;
	localparam int ACK_TIMEOUT  = 255;
	localparam logic [1:0] ST_OK      = 2'h0;
	localparam logic [1:0] ST_BUSERR  = 2'h1;
	localparam logic [1:0] ST_TIMEOUT = 2'h2;
	localparam logic [1:0] ST_REFUSED = 2'h3;
	typedef enum logic [1:0] {
		short_address_class,
		standard_address_class,
		extended_address_class,
		iack_mode
	} bcq_mode_t;
	typedef enum logic [2:0] {
		width_none,
		even_odd_byte_class,
		odd_byte_only_class,
		halfword_class,
		word_class
	} bcq_width_t;
	typedef struct packed {
		logic              write;
		bcq_mode_t         mode;
		logic [1:0]        size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bcq_req_t;
	typedef struct packed {
		logic [1:0]        status;
		logic [DATA_W-1:0] rdata;
	} bcq_rsp_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [AM_W-1:0]   address_modifier_code;
		logic              lword_n;
		logic              ds0_n;
		logic              ds1_n;
		logic              write_n;
		logic              as_n;
		logic              iack_n;
	} bcq_bus_t;
endpackage

/* File: sim/bcq_master_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bcq_master_tb;
	typedef struct packed {
		bcq_pkg::bcq_req_t req;
		logic [1:0]        st;
	} bcq_row_t;
	logic              core_clk, resetn, req_valid, req_ready, rsp_valid, dtack_n, berr_n, mute, fault;
	bcq_pkg::bcq_req_t req, r;
	bcq_pkg::bcq_rsp_t rsp, got;
	bcq_pkg::bcq_bus_t bus;
	logic [31:0]       data_o, data_oe_n, data_i, s_addr, s_wdata, m;
	logic [31:0]       amask [3];
	logic [5:0]        s_code;
	logic [5:0]        acode [3];
	int                s_cnt, n0, n1, odd_acks, cyc, mismatches, checks;
	logic              odd_dtack_n;
	bcq_row_t          rows [9];
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	bcq_master dut_u (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp(rsp), .bus(bus), .data_o(data_o), .data_oe_n(data_oe_n),
		.data_i(data_i), .dtack_n(dtack_n), .berr_n(berr_n));
	bcq_slave_model slv_u (.core_clk(core_clk), .bus(bus), .data_o(data_o), .mute(mute), .fault(fault),
		.data_i(data_i), .dtack_n(dtack_n), .berr_n(berr_n), .s_addr(s_addr), .s_wdata(s_wdata),
		.s_code(s_code), .s_cnt(s_cnt));
	bcq_slave_model #(.ODD_ONLY(1'b1)) odd_u (.core_clk(core_clk), .bus(bus), .data_o(data_o), .mute(1'b0),
		.fault(1'b0), .data_i(), .dtack_n(odd_dtack_n), .berr_n(), .s_addr(), .s_wdata(), .s_code(),
		.s_cnt());
	always @(posedge core_clk) begin
		if (odd_dtack_n === 1'b0)
			odd_acks++;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [31:0] lanes(input bcq_pkg::bcq_req_t q, input logic [31:0] v);
		case (q.size)
			2'h0:    lanes = q.addr[0] ? {24'h0, v[7:0]} : {16'h0, v[7:0], 8'h0};
			2'h1:    lanes = {16'h0, v[15:0]};
			default: lanes = v;
		endcase
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		pat = {a[8:1] ^ 8'h3c, a[8:1] ^ 8'h5a, a[8:1] ^ 8'h96, a[8:1]};
	endfunction
	task automatic row(input int i, input logic w, input bcq_pkg::bcq_mode_t md, input logic [1:0] sz,
		input logic [31:0] a, input logic [1:0] st);
		rows[i] = '{'{w, md, sz, a, ~a}, st};
	endtask
	task automatic run(input bcq_pkg::bcq_req_t q);
		int n;
		n0 = s_cnt;
		req = q;
		req_valid = 1'b1;
		@(posedge core_clk);
		#1 req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1 n++;
		end
		got = rsp;
		check("iack_n", 32'h1, 32'(bus.iack_n));
		@(posedge core_clk);
		#1;
	endtask
	initial begin
		resetn    = 1'b0;
		req_valid = 1'b0;
		req       = '0;
		mute      = 1'b0;
		fault     = 1'b0;
		amask = '{bcq_pkg::MASK_SHORT, bcq_pkg::MASK_STANDARD, bcq_pkg::MASK_EXTENDED};
		acode = '{bcq_pkg::AM_SHORT, bcq_pkg::AM_STANDARD, bcq_pkg::AM_EXTENDED};
		row(0, 1'b0, bcq_pkg::short_address_class, 2'h0, 32'h12345673, bcq_pkg::ST_OK);
		row(1, 1'b0, bcq_pkg::standard_address_class, 2'h0, 32'h00abcd02, bcq_pkg::ST_OK);
		row(2, 1'b0, bcq_pkg::extended_address_class, 2'h2, 32'hdeadbee0, bcq_pkg::ST_OK);
		row(3, 1'b1, bcq_pkg::short_address_class, 2'h1, 32'h0000f00e, bcq_pkg::ST_OK);
		row(4, 1'b1, bcq_pkg::extended_address_class, 2'h0, 32'h80000004, bcq_pkg::ST_OK);
		row(5, 1'b0, bcq_pkg::standard_address_class, 2'h1, 32'h00000101, bcq_pkg::ST_REFUSED);
		row(6, 1'b1, bcq_pkg::extended_address_class, 2'h2, 32'h00000002, bcq_pkg::ST_REFUSED);
		row(7, 1'b0, bcq_pkg::iack_mode, 2'h0, 32'h00000011, bcq_pkg::ST_REFUSED);
		row(8, 1'b0, bcq_pkg::standard_address_class, 2'h3, 32'h00000040, bcq_pkg::ST_REFUSED);
		repeat (2) @(posedge core_clk);
		#1 resetn = 1'b1;
		foreach (rows[i]) begin
			r = rows[i].req;
			n1 = odd_acks;
			run(r);
			m = lanes(r, 32'hffffffff);
			check("status", 32'(rows[i].st), 32'(got.status));
			check("odd_ack", 32'(r.size == 2'h0 && r.addr[0] && rows[i].st == bcq_pkg::ST_OK),
				32'(odd_acks != n1));
			if (rows[i].st == bcq_pkg::ST_REFUSED) begin
				check("bus_cycles", 32'(n0), 32'(s_cnt));
			end else begin
				check("addr", r.addr & amask[r.mode], s_addr & amask[r.mode]);
				check("code", 32'(acode[r.mode]), 32'(s_code));
				if (r.write)
					check("wdata", lanes(r, r.wdata) & m, s_wdata & m);
				else
					check("rdata", pat(r.addr) & m, lanes(r, got.rdata) & m);
			end
		end
		resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check("as_n", 32'h1, 32'(bus.as_n));
		check("data_oe_n", 32'hffffffff, data_oe_n);
		check("req_ready", 32'h1, 32'(req_ready));
		resetn = 1'b1;
		mute = 1'b1;
		run(rows[2].req);
		check("timeout", 32'(bcq_pkg::ST_TIMEOUT), 32'(got.status));
		mute = 1'b0;
		fault = 1'b1;
		run(rows[0].req);
		check("bus_error", 32'(bcq_pkg::ST_BUSERR), 32'(got.status));
		print_verdict();
	end
endmodule
`default_nettype wire

/* File: sim/bcq_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcq_slave_model #(
	parameter bit ODD_ONLY = 1'b0
) (
	input  wire logic              core_clk,
	input  wire bcq_pkg::bcq_bus_t bus,
	input  wire logic [31:0]       data_o,
	input  wire logic              mute,
	input  wire logic              fault,
	output logic [31:0]            data_i,
	output logic                   dtack_n,
	output logic                   berr_n,
	output logic [31:0]            s_addr,
	output logic [31:0]            s_wdata,
	output logic [5:0]             s_code,
	output int                     s_cnt
);
	logic [31:0] mk;
	logic        hit;
	always_comb begin
		case (bus.address_modifier_code)
			bcq_pkg::AM_SHORT:    mk = bcq_pkg::MASK_SHORT;
			bcq_pkg::AM_STANDARD: mk = bcq_pkg::MASK_STANDARD;
			bcq_pkg::AM_EXTENDED: mk = bcq_pkg::MASK_EXTENDED;
			default:              mk = 32'h0;
		endcase
		// The address strobe is watched, one of the two allowed choices.
		hit = (mk != 32'h0) && bus.iack_n && !bus.as_n && !(bus.ds0_n && bus.ds1_n);
		hit = hit && !(ODD_ONLY && (!bus.ds1_n || !bus.lword_n));
	end
	initial begin
		dtack_n = 1'b1;
		berr_n  = 1'b1;
		data_i  = 32'h0;
		s_cnt   = 0;
	end
	always @(negedge bus.as_n) begin
		s_addr = bus.addr;
		s_code = bus.address_modifier_code;
		s_cnt++;
	end
	always @(posedge core_clk) begin
		#1;
		if (hit && !mute) begin
			dtack_n = fault;
			berr_n  = !fault;
			if (bus.write_n)
				data_i = {bus.addr[8:1] ^ 8'h3c, bus.addr[8:1] ^ 8'h5a, bus.addr[8:1] ^ 8'h96, bus.addr[8:1]};
			else
				s_wdata = data_o;
		end else begin
			dtack_n = 1'b1;
			berr_n  = 1'b1;
			data_i  = ~data_i;
		end
	end
endmodule
`default_nettype wire
